// [include/compensated_oscillator_pkg.sv]
// Purpose: Constants, types and helpers for the oscillator and supply supervisor.
// Assumes: core_clk at 200 MHz; the oscillator tick arrives as a sampled pin.
// Notes: Register offsets are byte addresses on a 32-bit AHB-Lite bus.
`default_nettype none
package compensated_oscillator_pkg;
  localparam int unsigned CORE_MHZ = 200;
  localparam int unsigned CORE_KHZ = CORE_MHZ * 1000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned CONV_PERIOD_S = 64;
  localparam int unsigned CONV_TICKS = CONV_PERIOD_S * OSC_HZ;
  localparam int unsigned STOP_DETECT_MS = 100;
  localparam int unsigned STOP_DETECT_CYC = STOP_DETECT_MS * CORE_KHZ;
  localparam int unsigned RECOVERY_MS = 125;
  localparam int unsigned RECOVERY_CYC = RECOVERY_MS * CORE_KHZ;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CORE_KHZ;
  localparam int unsigned RST_ACTIVE_MS = 250;
  localparam int unsigned RST_ACTIVE_CYC = RST_ACTIVE_MS * CORE_KHZ;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CSTAT_OFS = 12'h004;
  localparam logic [11:0] AGING_OFS = 12'h008;
  localparam logic [11:0] TEMP_OFS = 12'h00c;
  localparam logic [11:0] TRIM_OFS = 12'h010;
  localparam logic [11:0] ISTAT_OFS = 12'h014;
  localparam logic [11:0] IMASK_OFS = 12'h018;
  localparam logic [11:0] STATE_OFS = 12'h01c;
  localparam logic [11:0] LUT_BASE = 12'h100;
  localparam int unsigned OSC_DIS_BIT = 7;
  localparam int unsigned WAVE_BATT_BIT = 6;
  localparam int unsigned IRQ_SEL_BIT = 2;
  localparam int unsigned OSF_BIT = 7;
  localparam int unsigned CLK_BATT_BIT = 6;
  localparam int unsigned RATE_LSB = 4;
  localparam int unsigned CLK_EN_BIT = 3;
  localparam int unsigned BUSY_BIT = 2;
  localparam logic [7:0] CTRL_WMASK = 8'hc4;
  localparam logic [7:0] CSTAT_WMASK = 8'h78;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] CSTAT_RST = 8'hc8;
  localparam int unsigned EV_CONV = 0;
  localparam int unsigned EV_OSF = 1;
  localparam int unsigned EV_PFAIL = 2;
  localparam int unsigned EV_PBUTTON = 3;
  localparam int unsigned EV_W = 4;
  typedef enum logic [0:0] {COMP_IDLE = 1'b0, COMP_LOOK = 1'b1} comp_state_t;
  typedef enum logic [2:0] {
    RS_IDLE = 3'b000, RS_PFAIL = 3'b001, RS_REC = 3'b010,
    RS_DEB = 3'b011, RS_WAIT = 3'b100, RS_HOLD = 3'b101
  } rst_state_t;
  // Saturating sum keeps a large negative offset from wrapping to full trim.
  function automatic logic [7:0] sat_trim(input logic [7:0] base, input logic [7:0] aging_offset);
    logic signed [9:0] s;
    s = $signed({2'h0, base}) + $signed({{2{aging_offset[7]}}, aging_offset});
    if (s < 10'sh000)
      sat_trim = 8'h00;
    else if (s > 10'sh0ff)
      sat_trim = 8'hff;
    else
      sat_trim = s[7:0];
  endfunction
endpackage
`default_nettype wire

// [hdl/trim_lut.sv]
// Purpose: Capacitance lookup table, one write port and two registered read ports.
// Assumes: Contents are loaded by software before they are needed.
// Notes: Port a serves the bus, port b the compensation sequencer.
`default_nettype none
module trim_lut #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
)(
  input wire logic clk, // core clock
  input wire logic we, // write strobe
  input wire logic [AW-1:0] waddr, // write index
  input wire logic [DW-1:0] wdata, // write data
  input wire logic [AW-1:0] raddr_a, // bus read index
  output logic [DW-1:0] rdata_a, // bus read data
  input wire logic [AW-1:0] raddr_b, // lookup read index
  output logic [DW-1:0] rdata_b // lookup read data
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
      mem_r[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    rdata_a <= mem_r[raddr_a];
    rdata_b <= mem_r[raddr_b];
  end
endmodule
`default_nettype wire

// [hdl/compensated_oscillator_power_supervisor.sv]
// Purpose: Oscillator trim, supply selection, stop detection and reset pin control.
// Assumes: Pins and the oscillator tick are asynchronous; sensor and alarm inputs are not.
// Notes: Registers sit behind an AHB-Lite slave with one wait state.
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`default_nettype none
module compensated_oscillator_power_supervisor #(
  parameter int unsigned LUT_AW = 6,
  parameter int unsigned TEMP_W = 10,
  parameter int unsigned CONV_TICKS = compensated_oscillator_pkg::CONV_TICKS,
  parameter int unsigned OSF_CYC = compensated_oscillator_pkg::STOP_DETECT_CYC,
  parameter int unsigned REC_CYC = compensated_oscillator_pkg::RECOVERY_CYC,
  parameter int unsigned DEB_CYC = compensated_oscillator_pkg::DEBOUNCE_CYC,
  parameter int unsigned RST_CYC = compensated_oscillator_pkg::RST_ACTIVE_CYC
)(
  input wire logic core_clk, // 200 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic hready, // AHB ready in
  input wire logic [31:0] hwdata, // AHB write data
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response, always OKAY
  input wire logic osc_clk_in, // oscillator tick pin
  input wire logic vcc_below_pf, // main supply below powerfail_threshold
  input wire logic vcc_below_bat, // main supply below battery
  input wire logic rst_pin_in, // reset pin level
  input wire logic addr_write_ok, // valid bus address write seen, pulse
  input wire logic temp_valid, // conversion result pulse
  input wire logic [TEMP_W-1:0] temp_value, // measured temperature
  input wire logic sqw_in, // square wave source
  input wire logic alarm_n_in, // alarm interrupt, active low
  output logic osc_run, // oscillator enable
  output logic conv_start, // conversion request pulse
  output logic batt_select, // supply from battery
  output logic [7:0] cap_sel, // capacitance trim
  output logic clkout, // clock output pin
  output logic irq_or_wave_out, // shared pin output value
  output logic irq_or_wave_oe_n, // shared pin enable, low drives
  output logic rst_pin_out, // reset pin output value
  output logic rst_pin_oe_n, // reset pin enable, low drives
  output logic irq // level interrupt
);
  generate
    if (LUT_AW > 6 || LUT_AW > TEMP_W)
    begin : bad_lut
      $error("LUT_AW must fit the table window and the temperature");
    end
    if (OSF_CYC < 2 || REC_CYC < 1 || DEB_CYC < 1 || RST_CYC < 1)
    begin : bad_cnt
      $error("timing counts too small");
    end
    if (CONV_TICKS >= 32'h1000_0000 || CONV_TICKS < 1)
    begin : bad_conv
      $error("CONV_TICKS out of range");
    end
  endgenerate

  function automatic logic reg_hit(input logic [11:0] idx, input logic [11:0] ofs);
    reg_hit = (idx[11:2] == ofs[11:2]);
  endfunction

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [3:0] pin_meta_r, pin_sync_r;
  // Pins reset to their idle level, so no false edge or early power-good follows reset.
  localparam logic [3:0] PIN_IDLE = 4'ha;
  logic [3:0] pin_raw;
  logic osc_s, pf_s, bat_s, rpin_s;
  logic osc_d_r, rpin_d_r, pf_d_r;
  logic osc_rise, pin_fall, main_up_rise;

  assign pin_raw = {rst_pin_in, vcc_below_bat, vcc_below_pf, osc_clk_in};

  // Every pin passes two flops before any logic looks at it.
  for (genvar g = 0; g < 4; g++)
  begin : sync
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
      begin
        pin_meta_r[g] <= PIN_IDLE[g];
        pin_sync_r[g] <= PIN_IDLE[g];
      end
      else
      begin
        pin_meta_r[g] <= pin_raw[g];
        pin_sync_r[g] <= pin_meta_r[g];
      end
    end
  end

  assign osc_s = pin_sync_r[0];
  assign pf_s = pin_sync_r[1];
  assign bat_s = pin_sync_r[2];
  assign rpin_s = pin_sync_r[3];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_d_r <= 1'b0;
      rpin_d_r <= 1'b1;
      pf_d_r <= 1'b1;
    end
    else
    begin
      osc_d_r <= osc_s;
      rpin_d_r <= rpin_s;
      pf_d_r <= pf_s;
    end
  end

  assign osc_rise = osc_s & ~osc_d_r;
  assign pin_fall = rpin_d_r & ~rpin_s;
  assign main_up_rise = pf_d_r & ~pf_s;

  localparam int unsigned EV_W_L = compensated_oscillator_pkg::EV_W;
  logic [7:0] ctrl_r, cstat_r, aging_r;
  logic [EV_W_L-1:0] status_r, status_nxt, mask_r, ev;
  logic osc_dis, irq_sel, wave_batt, clk_en, clk_batt;
  logic [1:0] conv_rate;
  logic virgin_r, busy_r;

  assign osc_dis = ctrl_r[compensated_oscillator_pkg::OSC_DIS_BIT];
  assign irq_sel = ctrl_r[compensated_oscillator_pkg::IRQ_SEL_BIT];
  assign wave_batt = ctrl_r[compensated_oscillator_pkg::WAVE_BATT_BIT];
  assign clk_en = cstat_r[compensated_oscillator_pkg::CLK_EN_BIT];
  assign clk_batt = cstat_r[compensated_oscillator_pkg::CLK_BATT_BIT];
  assign conv_rate = cstat_r[compensated_oscillator_pkg::RATE_LSB +: 2];

  // Supply choice and oscillator enable.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      batt_select <= 1'b0;
      virgin_r <= 1'b1;
      osc_run <= 1'b0;
    end
    else
    begin
      batt_select <= pf_s & bat_s;
      if (!pf_s || addr_write_ok)
        virgin_r <= 1'b0;
      // Main power or an address write once seen, the oscillator survives later losses unless osc_dis stops it on battery.
      osc_run <= !virgin_r && !(batt_select && osc_dis);
    end
  end

  // Conversion scheduling counts oscillator ticks, not core cycles.
  logic [31:0] tick_cnt_r, conv_period;
  logic conv_due;
  assign conv_period = CONV_TICKS << conv_rate;
  assign conv_due = osc_run && osc_rise && (tick_cnt_r == conv_period - 32'h1);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tick_cnt_r <= 32'h0;
      conv_start <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      if (main_up_rise || conv_due)
        tick_cnt_r <= 32'h0;
      else if (osc_run && osc_rise)
        tick_cnt_r <= tick_cnt_r + 32'h1;
      conv_start <= main_up_rise || (conv_due && !virgin_r);
      if (conv_start)
        busy_r <= 1'b1;
      else if (temp_valid)
        busy_r <= 1'b0;
    end
  end

  // Compensation: look up trim only for a new temperature.
  compensated_oscillator_pkg::comp_state_t comp_st;
  logic [TEMP_W-1:0] last_temp_r;
  logic last_ok_r;
  logic [LUT_AW-1:0] lut_idx_b, lut_idx_a, lut_widx;
  logic [7:0] lut_a, lut_b;
  logic new_temp;

  assign lut_idx_b = temp_value[TEMP_W-1 -: LUT_AW];
  assign new_temp = temp_valid && (!last_ok_r || temp_value != last_temp_r);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      comp_st <= compensated_oscillator_pkg::COMP_IDLE;
      last_temp_r <= '0;
      last_ok_r <= 1'b0;
      cap_sel <= 8'h00;
    end
    else
    begin
      case (comp_st)
        compensated_oscillator_pkg::COMP_IDLE:
        begin
          if (new_temp)
          begin
            last_temp_r <= temp_value;
            last_ok_r <= 1'b1;
            comp_st <= compensated_oscillator_pkg::COMP_LOOK;
          end
        end
        compensated_oscillator_pkg::COMP_LOOK:
        begin
          cap_sel <= compensated_oscillator_pkg::sat_trim(lut_b, aging_r);
          comp_st <= compensated_oscillator_pkg::COMP_IDLE;
        end
        default: comp_st <= compensated_oscillator_pkg::COMP_IDLE;
      endcase
    end
  end

  // Stop detection counts core cycles since the last rising oscillator edge.
  logic [31:0] stop_cnt_r;
  logic osf_ev;
  assign osf_ev = !osc_rise && (stop_cnt_r == OSF_CYC - 2);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      stop_cnt_r <= 32'h0;
    else if (osc_rise)
      stop_cnt_r <= 32'h0;
    else if (stop_cnt_r != OSF_CYC - 1)
      stop_cnt_r <= stop_cnt_r + 32'h1;
  end

  // Reset pin sequencer; power fail overrides any pushbutton phase.
  compensated_oscillator_pkg::rst_state_t rs_st, rs_nxt;
  logic [31:0] rcnt_r;

  always_comb
  begin
    rs_nxt = rs_st;
    case (rs_st)
      compensated_oscillator_pkg::RS_IDLE: if (pin_fall) rs_nxt = compensated_oscillator_pkg::RS_DEB;
      compensated_oscillator_pkg::RS_PFAIL:
        if (!pf_s) rs_nxt = osc_dis ? compensated_oscillator_pkg::RS_IDLE : compensated_oscillator_pkg::RS_REC;
      compensated_oscillator_pkg::RS_REC: if (rcnt_r == REC_CYC - 1) rs_nxt = compensated_oscillator_pkg::RS_IDLE;
      compensated_oscillator_pkg::RS_DEB: if (rcnt_r == DEB_CYC - 1) rs_nxt = compensated_oscillator_pkg::RS_WAIT;
      compensated_oscillator_pkg::RS_WAIT: if (rpin_s) rs_nxt = compensated_oscillator_pkg::RS_HOLD;
      compensated_oscillator_pkg::RS_HOLD: if (rcnt_r == RST_CYC - 1) rs_nxt = compensated_oscillator_pkg::RS_IDLE;
      default: rs_nxt = compensated_oscillator_pkg::RS_IDLE;
    endcase
    if (pf_s)
      rs_nxt = compensated_oscillator_pkg::RS_PFAIL;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rs_st <= compensated_oscillator_pkg::RS_IDLE;
      rcnt_r <= 32'h0;
      rst_pin_oe_n <= 1'b1;
      rst_pin_out <= 1'b0;
    end
    else
    begin
      rs_st <= rs_nxt;
      rcnt_r <= (rs_nxt != rs_st) ? 32'h0 : rcnt_r + 32'h1;
      rst_pin_out <= 1'b0;
      rst_pin_oe_n <= (rs_nxt == compensated_oscillator_pkg::RS_IDLE) || (rs_nxt == compensated_oscillator_pkg::RS_WAIT);
    end
  end

  // Pin outputs.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      clkout <= 1'b0;
      irq_or_wave_out <= 1'b0;
      irq_or_wave_oe_n <= 1'b1;
    end
    else
    begin
      clkout <= osc_s && osc_run && clk_en && clk_batt;
      irq_or_wave_out <= 1'b0;
      if (irq_sel)
        irq_or_wave_oe_n <= alarm_n_in;
      else
        irq_or_wave_oe_n <= sqw_in || (batt_select && !wave_batt);
    end
  end

  // AHB-Lite slave: address phase, one wait cycle, then the answer.
  logic ph_v_r, ph_wr_r, acc, wr_en, rd_en, lut_hit;
  logic [11:0] ph_idx_r;
  logic [31:0] rd_mux;

  assign acc = hsel && htrans[1] && hready;
  assign lut_idx_a = haddr[LUT_AW+1:2];
  assign lut_widx = ph_idx_r[LUT_AW+1:2];
  assign lut_hit = (ph_idx_r[11:8] == compensated_oscillator_pkg::LUT_BASE[11:8])
                   && ({1'b0, ph_idx_r[7:2]} < 7'(1 << LUT_AW));
  assign wr_en = ph_v_r && ph_wr_r;
  assign rd_en = ph_v_r && !ph_wr_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ph_v_r <= 1'b0;
      ph_wr_r <= 1'b0;
      ph_idx_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
    end
    else
    begin
      ph_v_r <= acc;
      hreadyout <= !acc;
      hresp <= 1'b0;
      if (acc)
      begin
        ph_wr_r <= hwrite && (hsize == 3'h2);
        ph_idx_r <= haddr[11:0];
      end
      if (rd_en)
        hrdata <= rd_mux;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0;
    if (reg_hit(ph_idx_r, compensated_oscillator_pkg::CTRL_OFS))
      rd_mux[7:0] = ctrl_r;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::CSTAT_OFS))
    begin
      rd_mux[7:0] = cstat_r;
      rd_mux[compensated_oscillator_pkg::BUSY_BIT] = busy_r;
    end
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::AGING_OFS))
      rd_mux[7:0] = aging_r;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::TEMP_OFS))
      rd_mux[TEMP_W-1:0] = last_temp_r;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::TRIM_OFS))
      rd_mux[7:0] = cap_sel;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::ISTAT_OFS))
      rd_mux[EV_W_L-1:0] = status_r;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::IMASK_OFS))
      rd_mux[EV_W_L-1:0] = mask_r;
    else if (reg_hit(ph_idx_r, compensated_oscillator_pkg::STATE_OFS))
      rd_mux[2:0] = {virgin_r, osc_run, batt_select};
    else if (lut_hit)
      rd_mux[7:0] = lut_a;
  end

  trim_lut #(.AW(LUT_AW), .DW(8)) u_lut (
    .clk(core_clk),
    .we(wr_en && lut_hit),
    .waddr(lut_widx),
    .wdata(hwdata[7:0]),
    .raddr_a(lut_idx_a),
    .rdata_a(lut_a),
    .raddr_b(lut_idx_b),
    .rdata_b(lut_b)
  );

  // Software registers; the stop flag is set by hardware and cleared by writing 0.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= compensated_oscillator_pkg::CTRL_RST;
      cstat_r <= compensated_oscillator_pkg::CSTAT_RST;
      aging_r <= 8'h00;
      mask_r <= '0;
    end
    else
    begin
      if (wr_en && reg_hit(ph_idx_r, compensated_oscillator_pkg::CTRL_OFS))
        ctrl_r <= hwdata[7:0] & compensated_oscillator_pkg::CTRL_WMASK;
      if (wr_en && reg_hit(ph_idx_r, compensated_oscillator_pkg::CSTAT_OFS))
      begin
        cstat_r[6:3] <= hwdata[6:3];
        if (!hwdata[compensated_oscillator_pkg::OSF_BIT])
          cstat_r[compensated_oscillator_pkg::OSF_BIT] <= 1'b0;
      end
      // A stop detected in the clearing cycle still leaves the flag set.
      if (osf_ev)
        cstat_r[compensated_oscillator_pkg::OSF_BIT] <= 1'b1;
      if (wr_en && reg_hit(ph_idx_r, compensated_oscillator_pkg::AGING_OFS))
        aging_r <= hwdata[7:0];
      if (wr_en && reg_hit(ph_idx_r, compensated_oscillator_pkg::IMASK_OFS))
        mask_r <= hwdata[EV_W_L-1:0];
    end
  end

  // Interrupt status: events are sticky, a read clears, a new event wins.
  always_comb
  begin
    ev = '0;
    ev[compensated_oscillator_pkg::EV_CONV] = temp_valid;
    ev[compensated_oscillator_pkg::EV_OSF] = osf_ev;
    ev[compensated_oscillator_pkg::EV_PFAIL] = (rs_nxt == compensated_oscillator_pkg::RS_PFAIL) && (rs_st != compensated_oscillator_pkg::RS_PFAIL);
    ev[compensated_oscillator_pkg::EV_PBUTTON] = (rs_nxt == compensated_oscillator_pkg::RS_DEB) && (rs_st != compensated_oscillator_pkg::RS_DEB);
    status_nxt = status_r;
    if (rd_en && reg_hit(ph_idx_r, compensated_oscillator_pkg::ISTAT_OFS))
      status_nxt = '0;
    status_nxt = status_nxt | ev;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq <= |(status_nxt & mask_r);
    end
  end

  sequence same_temp_s;
    comp_st == compensated_oscillator_pkg::COMP_IDLE && temp_valid && last_ok_r && temp_value == last_temp_r;
  endsequence
  sequence stop_reach_s;
    stop_cnt_r == OSF_CYC - 2 && !osc_rise;
  endsequence
  sequence pb_press_s;
    rs_st == compensated_oscillator_pkg::RS_IDLE && !pf_s && pin_fall;
  endsequence

  supply_sel_a: assert property (
    ##1 batt_select == $past(pf_s && bat_s)) else $error("supply choice wrong");
  first_batt_a: assert property (
    virgin_r |=> !osc_run) else $error("oscillator ran before first main power");
  batt_stop_a: assert property (
    batt_select && osc_dis |=> !osc_run) else $error("oscillator not stopped");
  keep_run_a: assert property (
    !virgin_r && !osc_dis |=> osc_run) else $error("oscillator stopped on battery");
  conv_first_a: assert property (
    main_up_rise |=> conv_start ##1 !conv_start) else $error("no conversion at power-up");
  trim_hold_a: assert property (
    same_temp_s |=> $stable(cap_sel) [*2]) else $error("trim reloaded without change");
  trim_load_a: assert property (
    comp_st == compensated_oscillator_pkg::COMP_LOOK
    |=> cap_sel == compensated_oscillator_pkg::sat_trim($past(lut_b), $past(aging_r)))
    else $error("trim is not table plus aging");
  stop_flag_a: assert property (
    stop_reach_s |=> cstat_r[compensated_oscillator_pkg::OSF_BIT]) else $error("stop flag not set");
  pf_drive_a: assert property (
    pf_s |=> !rst_pin_oe_n && rs_st == compensated_oscillator_pkg::RS_PFAIL) else $error("power fail not driven");
  rec_skip_a: assert property (
    rs_st == compensated_oscillator_pkg::RS_PFAIL && !pf_s && osc_dis
    |=> rst_pin_oe_n && rs_st == compensated_oscillator_pkg::RS_IDLE)
    else $error("recovery delay not bypassed");
  pb_debounce_a: assert property (
    pb_press_s |=> rs_st == compensated_oscillator_pkg::RS_DEB && !rst_pin_oe_n) else $error("pushbutton missed");
  wave_mode_a: assert property (
    !irq_sel && !sqw_in && !batt_select |=> !irq_or_wave_oe_n) else $error("wave not out");
  alarm_mode_a: assert property (
    irq_sel && alarm_n_in |=> irq_or_wave_oe_n) else $error("wave leaked in alarm mode");
  clkout_low_a: assert property (
    !(clk_en && clk_batt) |=> !clkout) else $error("clock pin not low");
  irq_level_a: assert property (
    ##1 irq == $past(|(status_nxt & mask_r))) else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [sim/pin_model.sv]
// Purpose: Board around the supervisor: crystal tick, reset pin and shared pin.
// Assumes: Both pins have pull-ups, so a released pin reads high.
// Notes: The tick stands still while stopped, as a dead crystal would.
`default_nettype none
module pin_model (
  input wire logic osc_on, // crystal running
  input wire logic btn, // pushbutton held
  input wire logic rst_oe_n, // reset pin drive, low pulls
  input wire logic irq_oe_n, // shared pin drive, low pulls
  output logic osc, // crystal tick
  output logic rst_wire, // reset pin level
  output logic irq_wire // shared pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial osc = 1'b0;
  always #80 if (osc_on) osc = ~osc;
  assign rst_wire = rst_oe_n & ~btn;
  assign irq_wire = irq_oe_n;
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the oscillator and supply supervisor.
// Assumes: Shortened counts, 200 MHz core clock, 160 ns crystal tick.
// Notes: Register traffic uses single AHB-Lite word transfers.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic osc, osc_on = 1'b1, btn = 1'b0, rst_wire, irq_wire, powerfail_threshold = 1'b1, vbat = 1'b1;
  logic awok = 1'b0, tvalid = 1'b0, sqw = 1'b0, alarm_n = 1'b1;
  logic [9:0] temp = 10'h0;
  logic osc_run, conv_start, batt, clkout, iw_out, iw_oe_n, rp_out, rp_oe_n, irq;
  logic [7:0] cap_sel, aging_offset, lut;
  int n_errors = 0, checks_done = 0, cyc = 0, n_conv = 0, n_clk = 0;
  compensated_oscillator_power_supervisor #(.CONV_TICKS(8), .OSF_CYC(40), .REC_CYC(10), .DEB_CYC(10),
    .RST_CYC(10)) uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .osc_clk_in(osc),
    .vcc_below_pf(powerfail_threshold), .vcc_below_bat(vbat), .rst_pin_in(rst_wire),
    .addr_write_ok(awok), .temp_valid(tvalid), .temp_value(temp), .sqw_in(sqw),
    .alarm_n_in(alarm_n), .osc_run(osc_run), .conv_start(conv_start), .batt_select(batt),
    .cap_sel(cap_sel), .clkout(clkout), .irq_or_wave_out(iw_out),
    .irq_or_wave_oe_n(iw_oe_n), .rst_pin_out(rp_out), .rst_pin_oe_n(rp_oe_n), .irq(irq));
  pin_model pm (.osc_on(osc_on), .btn(btn), .rst_oe_n(rp_oe_n), .irq_oe_n(iw_oe_n),
    .osc(osc), .rst_wire(rst_wire), .irq_wire(irq_wire));
  assign hready = hreadyout;
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic results;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hung handshake would stall forever; the cycle ceiling turns it into a failure.
  always @(posedge core_clk)
  begin
    cyc++;
    if (conv_start === 1'b1)
      n_conv++;
    if (clkout === 1'b1)
      n_clk++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(q, e);
    chk(hresp, 1'b0);
  endtask
  task automatic pulse(input logic [9:0] t);
    tvalid <= 1'b1;
    temp <= t;
    tick(1);
    tvalid <= 1'b0;
    tick(4);
  endtask
  function automatic logic [7:0] trim_exp(input logic [7:0] b, input logic [7:0] a);
    int s;
    s = int'(b) + int'($signed(a));
    if (s < 0)
      return 8'h00;
    return s > 255 ? 8'hff : 8'(s);
  endfunction
  initial
  begin
    logic [9:0] tv;
    void'($urandom(12));
    tick(12);
    rst <= 1'b0;
    tick(40);
    chk(osc_run, 1'b0);
    chk(n_conv, 0);
    chk(batt, 1'b1);
    chk(rp_oe_n, 1'b0);
    awok <= 1'b1;
    tick(1);
    awok <= 1'b0;
    tick(6);
    chk(osc_run, 1'b1);
    rd(32'h000, 32'h04);
    rd(32'h004, 32'hc8);
    rd(32'h020, 32'h00);
    vbat <= 1'b0;
    tick(6);
    chk(batt, 1'b0);
    n_conv = 0;
    powerfail_threshold <= 1'b0;
    tick(6);
    chk(rp_oe_n, 1'b0);
    tick(12);
    chk(rp_oe_n, 1'b1);
    chk(n_conv != 0, 1'b1);
    powerfail_threshold <= 1'b1;
    vbat <= 1'b1;
    tick(400);
    chk(osc_run, 1'b1);
    powerfail_threshold <= 1'b0;
    vbat <= 1'b0;
    tick(30);
    n_conv = 0;
    tick(600);
    chk(n_conv == 2 || n_conv == 3, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      tv = {6'(i * 9 + 1), 4'($urandom)};
      lut = i == 0 ? 8'h10 : i == 1 ? 8'hf0 : 8'($urandom);
      aging_offset = i == 0 ? 8'h80 : i == 1 ? 8'h7f : 8'($urandom);
      ahb(1'b1, 32'h100 + {tv[9:4], 2'h0}, {24'h0, lut});
      ahb(1'b1, 32'h008, {24'h0, aging_offset});
      pulse(tv);
      chk(cap_sel, trim_exp(lut, aging_offset));
      ahb(1'b1, 32'h008, {24'h0, aging_offset ^ 8'h01});
      pulse(tv);
      chk(cap_sel, trim_exp(lut, aging_offset));
    end
    ahb(1'b1, 32'h004, 32'h48);
    ahb(1'b1, 32'h018, 32'h02);
    ahb(1'b0, 32'h014, 32'h0);
    tick(2);
    chk(irq, 1'b0);
    osc_on <= 1'b0;
    tick(100);
    chk(irq, 1'b1);
    // A result clears busy; no conversion can start while the crystal is stopped.
    pulse(tv);
    rd(32'h004, 32'hc8);
    osc_on <= 1'b1;
    tick(10);
    ahb(1'b0, 32'h014, 32'h0);
    chk(q[1], 1'b1);
    tick(2);
    chk(irq, 1'b0);
    n_clk = 0;
    tick(200);
    chk(n_clk != 0, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      ahb(1'b1, 32'h004, i == 0 ? 32'h40 : 32'h08);
      tick(3);
      n_clk = 0;
      tick(200);
      chk(n_clk, 0);
    end
    ahb(1'b1, 32'h004, 32'h58);
    n_conv = 0;
    tick(1100);
    chk(n_conv == 2 || n_conv == 3, 1'b1);
    for (int m = 0; m < 2; m++)
    begin
      ahb(1'b1, 32'h000, m == 0 ? 32'h04 : 32'h00);
      for (int k = 0; k < 6; k++)
      begin
        sqw <= 1'($urandom);
        alarm_n <= 1'($urandom);
        tick(3);
        chk(irq_wire, m == 0 ? alarm_n : sqw);
      end
    end
    ahb(1'b1, 32'h000, 32'h80);
    powerfail_threshold <= 1'b1;
    vbat <= 1'b1;
    tick(8);
    chk(osc_run, 1'b0);
    powerfail_threshold <= 1'b0;
    vbat <= 1'b0;
    tick(6);
    chk(rp_oe_n, 1'b1);
    btn <= 1'b1;
    tick(6);
    chk(rp_oe_n, 1'b0);
    btn <= 1'b0;
    tick(16);
    chk(rp_oe_n, 1'b0);
    tick(40);
    chk(rp_oe_n, 1'b1);
    chk(rp_out, 1'b0);
    chk(iw_out, 1'b0);
    results();
  end
endmodule
`default_nettype wire
